// File: design/ssel_pkg.sv
package ssel_pkg;

    // Register port geometry
    localparam int SSEL_AW = 4;
    localparam int SSEL_DW = 32;

    // Datapath widths
    localparam int SSEL_ID_W = 6;
    localparam int SSEL_PC_W = 32;
    localparam int SSEL_CNT_W = 24;
    localparam int SSEL_LAT_W = 12;
    localparam int SSEL_EXTRA_W = 8;
    localparam int SSEL_EVT_W = 8;
    localparam int SSEL_LFSR_W = 16;
    localparam int SSEL_COLL_W = 16;

    // Sampled operations that may be in flight at once
    localparam int SSEL_SLOTS = 2;
    localparam logic [1:0] SSEL_MAX_INFLIGHT = 2'h2;

    // Register word offsets
    localparam logic [SSEL_AW-1:0] SSEL_OFS_CTRL = 4'h0;
    localparam logic [SSEL_AW-1:0] SSEL_OFS_RELOAD = 4'h1;
    localparam logic [SSEL_AW-1:0] SSEL_OFS_COUNTER = 4'h2;
    localparam logic [SSEL_AW-1:0] SSEL_OFS_STATUS = 4'h3;
    localparam logic [SSEL_AW-1:0] SSEL_OFS_COLL_CNT = 4'h4;
    localparam logic [SSEL_AW-1:0] SSEL_OFS_FILTER = 4'h5;

    // Control fields
    localparam int SSEL_CTRL_EN_BIT = 0;
    localparam int SSEL_CTRL_RAND_BIT = 1;
    localparam int SSEL_CTRL_MASK_LSB = 8;

    // Status fields
    localparam int SSEL_STAT_COLL_BIT = 0;
    localparam int SSEL_STAT_EXTRA_BIT = 1;
    localparam int SSEL_STAT_INFL_LSB = 2;
    localparam int SSEL_STAT_NARROW_BIT = 4;
    localparam int SSEL_STAT_ENABLED_BIT = 5;

    // Filter fields
    localparam int SSEL_FILT_TYPE_LSB = 0;
    localparam int SSEL_FILT_EL_LSB = 4;
    localparam int SSEL_FILT_EVT_LSB = 8;
    localparam int SSEL_FILT_LAT_LSB = 16;

    // Values after reset, and the latency saturation limit
    localparam logic [SSEL_CNT_W-1:0] SSEL_RST_CNT = 24'h00_0000;
    localparam logic [SSEL_EXTRA_W-1:0] SSEL_RST_EXTRA = 8'h00;
    localparam logic [SSEL_EXTRA_W-1:0] SSEL_RST_MASK = 8'h00;
    localparam logic [3:0] SSEL_RST_TYPE_MASK = 4'hf;
    localparam logic [3:0] SSEL_RST_EL_MASK = 4'hf;
    localparam logic [SSEL_EVT_W-1:0] SSEL_RST_EVT_REQ = 8'h00;
    localparam logic [SSEL_LAT_W-1:0] SSEL_RST_LAT_MIN = 12'h000;
    localparam logic [SSEL_LAT_W-1:0] SSEL_LAT_MAX = 12'hfff;
    localparam logic [SSEL_COLL_W-1:0] SSEL_RST_COLL = 16'h0000;
    localparam logic [SSEL_DW-1:0] SSEL_ZERO_WORD = 32'h0000_0000;

    // Pseudorandom generator: nonzero seed, Galois taps
    localparam logic [SSEL_LFSR_W-1:0] SSEL_LFSR_SEED = 16'hace1;
    localparam logic [SSEL_LFSR_W-1:0] SSEL_LFSR_TAPS = 16'hb400;

    // End-of-lifetime codes on the completion port
    localparam logic [1:0] SSEL_END_COMMIT = 2'h0;
    localparam logic [1:0] SSEL_END_EXCEPT = 2'h1;
    localparam logic [1:0] SSEL_END_DISCARD = 2'h2;
    localparam logic [1:0] SSEL_END_REPLAY = 2'h3;

    typedef enum logic {
        PH_COUNT,
        PH_EXTRA
    } ssel_phase_t;

    typedef struct packed {
        logic valid;
        logic pop;
        logic [SSEL_ID_W-1:0] id;
        logic [SSEL_PC_W-1:0] pc;
    } ssel_op_t;

    typedef struct packed {
        logic valid;
        logic [SSEL_ID_W-1:0] id;
        logic [1:0] kind;
        logic [1:0] optype;
        logic [1:0] el;
        logic [SSEL_EVT_W-1:0] events;
        logic [SSEL_PC_W-1:0] addr;
    } ssel_done_t;

    typedef struct packed {
        logic [SSEL_ID_W-1:0] id;
        logic [1:0] kind;
        logic [1:0] optype;
        logic [1:0] el;
        logic [SSEL_PC_W-1:0] pc;
        logic [SSEL_EVT_W-1:0] events;
        logic [SSEL_LAT_W-1:0] latency;
        logic [SSEL_PC_W-1:0] addr;
    } ssel_rec_t;

endpackage : ssel_pkg

// File: design/ssel_top.sv
`timescale 1ns/100ps
`default_nettype none

module ssel_top
    import ssel_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [SSEL_AW-1:0] reg_addr,
    input wire logic [SSEL_DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [SSEL_DW-1:0] reg_rdata,
    input wire logic narrow_state,
    input wire ssel_op_t op_in,
    input wire ssel_done_t done_in,
    output logic pop_event,
    output logic feed_event,
    output logic collision_event,
    output logic tag_valid,
    output logic [SSEL_ID_W-1:0] tag_id,
    output logic rec_valid,
    output logic rec_dropped,
    output ssel_rec_t rec_out
);

    // Software state
    logic ctrl_en;
    logic rand_en;
    logic [SSEL_EXTRA_W-1:0] rand_mask;
    logic [SSEL_CNT_W-1:0] reload_val;
    logic [SSEL_CNT_W-1:0] interval_cnt;
    logic coll_flag;
    logic [SSEL_COLL_W-1:0] coll_cnt;
    logic [3:0] type_mask;
    logic [3:0] el_mask;
    logic [SSEL_EVT_W-1:0] evt_req;
    logic [SSEL_LAT_W-1:0] lat_min;

    // Selection state
    ssel_phase_t phase;
    ssel_phase_t next_phase;
    logic [SSEL_EXTRA_W-1:0] extra_cnt;
    logic [SSEL_LFSR_W-1:0] lfsr;

    // In-flight slots
    logic [SSEL_SLOTS-1:0] slot_valid;
    logic [SSEL_ID_W-1:0] slot_id [SSEL_SLOTS];
    logic [SSEL_PC_W-1:0] slot_pc [SSEL_SLOTS];
    logic [SSEL_LAT_W-1:0] slot_lat [SSEL_SLOTS];

    // Register decode
    wire logic wr_ctrl = reg_write && (reg_addr == SSEL_OFS_CTRL);
    wire logic wr_reload = reg_write && (reg_addr == SSEL_OFS_RELOAD);
    wire logic wr_counter = reg_write && (reg_addr == SSEL_OFS_COUNTER);
    wire logic wr_status = reg_write && (reg_addr == SSEL_OFS_STATUS);
    wire logic wr_coll = reg_write && (reg_addr == SSEL_OFS_COLL_CNT);
    wire logic wr_filter = reg_write && (reg_addr == SSEL_OFS_FILTER);

    // Population gating
    wire logic enabled = ctrl_en && !narrow_state;
    wire logic pop_op = op_in.valid && op_in.pop && enabled;

    // Selection decision
    wire logic [SSEL_EXTRA_W-1:0] extra_init = lfsr[SSEL_EXTRA_W-1:0] & rand_mask;
    wire logic want_extra = rand_en && (extra_init != SSEL_RST_EXTRA);
    wire logic cnt_at_zero = (interval_cnt <= SSEL_CNT_W'(1));
    wire logic extra_at_zero = (extra_cnt <= SSEL_EXTRA_W'(1));
    wire logic in_count = (phase == PH_COUNT);
    wire logic start_extra = pop_op && in_count && cnt_at_zero && want_extra;
    wire logic sel_from_count = in_count && cnt_at_zero && !want_extra;
    wire logic sel_from_extra = !in_count && extra_at_zero;
    wire logic select_now = pop_op && (sel_from_count || sel_from_extra);

    // Slot occupancy and collision
    wire logic [1:0] inflight = {1'b0, slot_valid[0]} + {1'b0, slot_valid[1]};
    wire logic collide = select_now && (inflight >= SSEL_MAX_INFLIGHT);
    wire logic tag_now = select_now && !collide;
    wire logic alloc_idx = slot_valid[0];

    // Completion match and per-slot claim
    wire logic [SSEL_SLOTS-1:0] match;
    wire logic [SSEL_SLOTS-1:0] claim;
    wire logic [SSEL_SLOTS-1:0] lat_full;
    genvar gi;
    generate
        for (gi = 0; gi < SSEL_SLOTS; gi++) begin : g_match
            // Any end kind closes the lifetime
            assign match[gi] = done_in.valid && slot_valid[gi] && (slot_id[gi] == done_in.id);
            assign claim[gi] = tag_now && (alloc_idx == 1'(gi));
            assign lat_full[gi] = (slot_lat[gi] == SSEL_LAT_MAX);
        end
    endgenerate
    wire logic done_hit = |match;
    wire logic hit_idx = match[1];
    wire logic [SSEL_LAT_W-1:0] hit_lat = slot_lat[hit_idx];

    // Record filter
    wire logic type_ok = type_mask[done_in.optype];
    wire logic el_ok = el_mask[done_in.el];
    wire logic evt_ok = ((done_in.events & evt_req) == evt_req);
    wire logic lat_ok = (hit_lat >= lat_min);
    wire logic rec_pass = type_ok && el_ok && evt_ok && lat_ok;

    // Next interval count
    logic [SSEL_CNT_W-1:0] next_interval_cnt;
    always_comb begin
        next_interval_cnt = interval_cnt;
        if (wr_counter) begin
            next_interval_cnt = reg_wdata[SSEL_CNT_W-1:0];
        end else if (select_now) begin
            next_interval_cnt = reload_val;
        end else if (pop_op && in_count && (interval_cnt != SSEL_RST_CNT)) begin
            next_interval_cnt = interval_cnt - SSEL_CNT_W'(1);
        end
    end

    // Next extra count
    logic [SSEL_EXTRA_W-1:0] next_extra_cnt;
    always_comb begin
        next_extra_cnt = extra_cnt;
        if (start_extra) begin
            next_extra_cnt = extra_init;
        end else if (pop_op && !in_count && !extra_at_zero) begin
            next_extra_cnt = extra_cnt - SSEL_EXTRA_W'(1);
        end
    end

    // Phase sequencing; held while disabled
    always_comb begin
        next_phase = phase;
        case (phase)
            PH_COUNT: begin
                if (start_extra) begin
                    next_phase = PH_EXTRA;
                end
            end
            PH_EXTRA: begin
                if (select_now) begin
                    next_phase = PH_COUNT;
                end
            end
            default: begin
                next_phase = PH_COUNT;
            end
        endcase
    end

    // Galois shift, runs every cycle
    wire logic [SSEL_LFSR_W-1:0] next_lfsr = lfsr[0] ? ((lfsr >> 1) ^ SSEL_LFSR_TAPS) : (lfsr >> 1);

    // Collision bookkeeping: a new collision wins over a clear
    wire logic coll_clr = wr_status && reg_wdata[SSEL_STAT_COLL_BIT];
    wire logic next_coll_flag = collide || (coll_flag && !coll_clr);
    wire logic [SSEL_COLL_W-1:0] coll_base = wr_coll ? SSEL_RST_COLL : coll_cnt;
    wire logic [SSEL_COLL_W-1:0] next_coll_cnt = collide ? (coll_base + SSEL_COLL_W'(1)) : coll_base;

    // Read mux
    wire logic [SSEL_DW-1:0] rd_ctrl = SSEL_ZERO_WORD
        | (SSEL_DW'(ctrl_en) << SSEL_CTRL_EN_BIT)
        | (SSEL_DW'(rand_en) << SSEL_CTRL_RAND_BIT)
        | (SSEL_DW'(rand_mask) << SSEL_CTRL_MASK_LSB);
    wire logic [SSEL_DW-1:0] rd_status = SSEL_ZERO_WORD
        | (SSEL_DW'(coll_flag) << SSEL_STAT_COLL_BIT)
        | (SSEL_DW'(!in_count) << SSEL_STAT_EXTRA_BIT)
        | (SSEL_DW'(inflight) << SSEL_STAT_INFL_LSB)
        | (SSEL_DW'(narrow_state) << SSEL_STAT_NARROW_BIT)
        | (SSEL_DW'(enabled) << SSEL_STAT_ENABLED_BIT);
    wire logic [SSEL_DW-1:0] rd_filter = SSEL_ZERO_WORD
        | (SSEL_DW'(type_mask) << SSEL_FILT_TYPE_LSB)
        | (SSEL_DW'(el_mask) << SSEL_FILT_EL_LSB)
        | (SSEL_DW'(evt_req) << SSEL_FILT_EVT_LSB)
        | (SSEL_DW'(lat_min) << SSEL_FILT_LAT_LSB);
    wire logic [SSEL_DW-1:0] rd_word =
        (reg_addr == SSEL_OFS_CTRL) ? rd_ctrl :
        (reg_addr == SSEL_OFS_RELOAD) ? SSEL_DW'(reload_val) :
        (reg_addr == SSEL_OFS_COUNTER) ? SSEL_DW'(interval_cnt) :
        (reg_addr == SSEL_OFS_STATUS) ? rd_status :
        (reg_addr == SSEL_OFS_COLL_CNT) ? SSEL_DW'(coll_cnt) :
        (reg_addr == SSEL_OFS_FILTER) ? rd_filter :
        SSEL_ZERO_WORD;
    wire logic [SSEL_DW-1:0] next_rdata = reg_read ? rd_word : SSEL_ZERO_WORD;

    // Record assembled from the slot and the completion
    ssel_rec_t next_rec;
    always_comb begin
        next_rec.id = done_in.id;
        next_rec.kind = done_in.kind;
        next_rec.optype = done_in.optype;
        next_rec.el = done_in.el;
        next_rec.pc = slot_pc[hit_idx];
        next_rec.events = done_in.events;
        next_rec.latency = hit_lat;
        next_rec.addr = done_in.addr;
    end

    // Control and reload registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_en <= 1'b0;
            rand_en <= 1'b0;
            rand_mask <= SSEL_RST_MASK;
            reload_val <= SSEL_RST_CNT;
        end else begin
            if (wr_ctrl) begin
                ctrl_en <= reg_wdata[SSEL_CTRL_EN_BIT];
                rand_en <= reg_wdata[SSEL_CTRL_RAND_BIT];
                rand_mask <= reg_wdata[SSEL_CTRL_MASK_LSB +: SSEL_EXTRA_W];
            end
            if (wr_reload) begin
                reload_val <= reg_wdata[SSEL_CNT_W-1:0];
            end
        end
    end

    // Record filter register
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            type_mask <= SSEL_RST_TYPE_MASK;
            el_mask <= SSEL_RST_EL_MASK;
            evt_req <= SSEL_RST_EVT_REQ;
            lat_min <= SSEL_RST_LAT_MIN;
        end else begin
            if (wr_filter) begin
                type_mask <= reg_wdata[SSEL_FILT_TYPE_LSB +: 4];
                el_mask <= reg_wdata[SSEL_FILT_EL_LSB +: 4];
                evt_req <= reg_wdata[SSEL_FILT_EVT_LSB +: SSEL_EVT_W];
                lat_min <= reg_wdata[SSEL_FILT_LAT_LSB +: SSEL_LAT_W];
            end
        end
    end

    // Counting state
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase <= PH_COUNT;
            interval_cnt <= SSEL_RST_CNT;
            extra_cnt <= SSEL_RST_EXTRA;
        end else begin
            phase <= next_phase;
            interval_cnt <= next_interval_cnt;
            extra_cnt <= next_extra_cnt;
        end
    end

    // Generator comes out of reset seeded, never all zeros
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lfsr <= SSEL_LFSR_SEED;
        end else begin
            lfsr <= next_lfsr;
        end
    end

    // Collision status
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            coll_flag <= 1'b0;
            coll_cnt <= SSEL_RST_COLL;
        end else begin
            coll_flag <= next_coll_flag;
            coll_cnt <= next_coll_cnt;
        end
    end

    // Next slot state; latency saturates
    logic [SSEL_SLOTS-1:0] next_slot_valid;
    logic [SSEL_ID_W-1:0] next_slot_id [SSEL_SLOTS];
    logic [SSEL_PC_W-1:0] next_slot_pc [SSEL_SLOTS];
    logic [SSEL_LAT_W-1:0] next_slot_lat [SSEL_SLOTS];
    always_comb begin
        for (int i = 0; i < SSEL_SLOTS; i++) begin
            next_slot_valid[i] = slot_valid[i];
            next_slot_id[i] = slot_id[i];
            next_slot_pc[i] = slot_pc[i];
            next_slot_lat[i] = slot_lat[i];
            if (claim[i]) begin
                next_slot_valid[i] = 1'b1;
                next_slot_id[i] = op_in.id;
                next_slot_pc[i] = op_in.pc;
                next_slot_lat[i] = SSEL_RST_LAT_MIN;
            end else if (match[i]) begin
                next_slot_valid[i] = 1'b0;
            end else if (slot_valid[i] && !lat_full[i]) begin
                next_slot_lat[i] = slot_lat[i] + SSEL_LAT_W'(1);
            end
        end
    end

    // Slot registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            slot_valid <= '0;
            for (int i = 0; i < SSEL_SLOTS; i++) begin
                slot_id[i] <= '0;
                slot_pc[i] <= '0;
                slot_lat[i] <= SSEL_RST_LAT_MIN;
            end
        end else begin
            slot_valid <= next_slot_valid;
            for (int i = 0; i < SSEL_SLOTS; i++) begin
                slot_id[i] <= next_slot_id[i];
                slot_pc[i] <= next_slot_pc[i];
                slot_lat[i] <= next_slot_lat[i];
            end
        end
    end

    // Event and tag outputs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pop_event <= 1'b0;
            feed_event <= 1'b0;
            collision_event <= 1'b0;
            tag_valid <= 1'b0;
            tag_id <= '0;
        end else begin
            pop_event <= pop_op;
            feed_event <= tag_now;
            collision_event <= collide;
            tag_valid <= tag_now;
            tag_id <= op_in.id;
        end
    end

    // Record capture after lifetime end only
    wire logic rec_keep = done_hit && rec_pass;
    wire logic rec_skip = done_hit && !rec_pass;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rec_valid <= 1'b0;
            rec_dropped <= 1'b0;
            rec_out <= '0;
        end else begin
            rec_valid <= rec_keep;
            rec_dropped <= rec_skip;
            if (done_hit) begin
                rec_out <= next_rec;
            end
        end
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= SSEL_ZERO_WORD;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule : ssel_top

`default_nettype wire

// File: testbench/ssel_chk_sva.sv
`timescale 1ns/100ps
`default_nettype none

module ssel_chk
    import ssel_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic narrow_state,
    input wire ssel_op_t op_in,
    input wire ssel_done_t done_in,
    input wire logic pop_event,
    input wire logic feed_event,
    input wire logic collision_event,
    input wire logic tag_valid,
    input wire logic [SSEL_ID_W-1:0] tag_id,
    input wire logic rec_valid,
    input wire logic rec_dropped,
    input wire ssel_rec_t rec_out
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    chk_feed_is_tag: assert property (feed_event == tag_valid)
        else $error("feed and tag pulses differ");
    chk_pop_cause: assert property (pop_event |-> $past(op_in.valid) && $past(op_in.pop) && !$past(narrow_state))
        else $error("population pulse without a counted op");
    chk_narrow_quiet: assert property (op_in.valid && narrow_state |=> !pop_event && !feed_event)
        else $error("activity in narrow state");
    chk_excl_quiet: assert property (op_in.valid && !op_in.pop |=> !pop_event && !feed_event)
        else $error("excluded op was counted");
    chk_select_counted: assert property (feed_event || collision_event |-> pop_event)
        else $error("selection without population pulse");
    chk_tag_id_match: assert property (tag_valid |-> tag_id == $past(op_in.id))
        else $error("tag id differs from op id");
    chk_coll_untagged: assert property (collision_event |-> !tag_valid)
        else $error("collided op was tagged");
    chk_rec_after_end: assert property (rec_valid || rec_dropped |-> $past(done_in.valid) && rec_out.id == $past(done_in.id))
        else $error("record without lifetime end");
    chk_rec_one_way: assert property (rec_valid |-> !rec_dropped)
        else $error("record both kept and dropped");
endmodule : ssel_chk

bind ssel_top ssel_chk ssel_chk_i (
    .clock(clock), .arst_n(arst_n), .narrow_state(narrow_state), .op_in(op_in), .done_in(done_in),
    .pop_event(pop_event), .feed_event(feed_event), .collision_event(collision_event),
    .tag_valid(tag_valid), .tag_id(tag_id), .rec_valid(rec_valid), .rec_dropped(rec_dropped), .rec_out(rec_out)
);

`default_nettype wire

// File: testbench/ssel_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none

module ssel_pipe_model
    import ssel_pkg::*;
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic issue,
    input wire logic issue_pop,
    input wire logic retire,
    input wire logic [1:0] retire_kind,
    input wire logic tag_valid,
    input wire logic [SSEL_ID_W-1:0] tag_id,
    output ssel_op_t op_in,
    output ssel_done_t done_in
);
    logic [SSEL_ID_W-1:0] seq_id;
    logic [SSEL_ID_W-1:0] live[$];
    ssel_op_t next_op;
    ssel_done_t next_done;

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            op_in <= '0;
            done_in <= '0;
            seq_id <= '0;
            live.delete();
        end else begin
            // Idle fields toggle so stale values never look valid
            next_op = ~op_in;
            next_op.valid = 1'b0;
            next_done = ~done_in;
            next_done.valid = 1'b0;
            if (issue) begin
                next_op = '{1'b1, issue_pop, seq_id, 32'h0000_1000};
                seq_id <= seq_id + 1'b1;
            end
            if (tag_valid) begin
                live.push_back(tag_id);
            end
            if (retire && live.size() > 0) begin
                next_done = '{1'b1, live[0], retire_kind, 2'h0, 2'h0, 8'h00, 32'h0000_2000};
                live.pop_front();
            end
            op_in <= next_op;
            done_in <= next_done;
        end
    end
endmodule : ssel_pipe_model

`default_nettype wire

// File: testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb
    import ssel_pkg::*;
;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [SSEL_AW-1:0] reg_addr = '0;
    logic [SSEL_DW-1:0] reg_wdata = '0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic narrow_state = 1'b0;
    logic issue = 1'b0;
    logic issue_pop = 1'b0;
    logic retire = 1'b0;
    logic [1:0] retire_kind = 2'h0;
    logic [SSEL_DW-1:0] reg_rdata;
    ssel_op_t op_in;
    ssel_done_t done_in;
    ssel_rec_t rec_out;
    logic pop_event, feed_event, collision_event, tag_valid, rec_valid, rec_dropped;
    logic [SSEL_ID_W-1:0] tag_id;
    logic [SSEL_ID_W-1:0] last_tag = '0;
    logic [1:0] last_kind = 2'h0;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;
    int n_ops = 0;
    int n_pop = 0, n_feed = 0, n_coll = 0, n_rec = 0, n_drop = 0;

    ssel_top ssel_top_i (
        .clock(clock), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .narrow_state(narrow_state),
        .op_in(op_in), .done_in(done_in), .pop_event(pop_event), .feed_event(feed_event),
        .collision_event(collision_event), .tag_valid(tag_valid), .tag_id(tag_id),
        .rec_valid(rec_valid), .rec_dropped(rec_dropped), .rec_out(rec_out)
    );

    ssel_pipe_model ssel_pipe_model_i (
        .clock(clock), .arst_n(arst_n), .issue(issue), .issue_pop(issue_pop), .retire(retire),
        .retire_kind(retire_kind), .tag_valid(tag_valid), .tag_id(tag_id), .op_in(op_in), .done_in(done_in)
    );

    initial begin
        forever #12.5 clock = ~clock;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic wr(input logic [SSEL_AW-1:0] a, input logic [SSEL_DW-1:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [SSEL_AW-1:0] a, input logic [SSEL_DW-1:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 cmp($sformatf("reg %0h", a), exp, reg_rdata);
    endtask : rd

    // Back-to-back ops, then time for the event pulses to land
    task automatic ops(input int n, input logic p, input logic nw);
        @(posedge clock);
        issue <= 1'b1;
        issue_pop <= p;
        narrow_state <= nw;
        repeat (n) @(posedge clock);
        issue <= 1'b0;
        n_ops += n;
        repeat (4) @(posedge clock);
        narrow_state <= 1'b0;
    endtask : ops

    task automatic ret(input logic [1:0] k);
        @(posedge clock);
        retire <= 1'b1;
        retire_kind <= k;
        @(posedge clock);
        retire <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : ret

    always @(posedge clock) begin
        cycles++;
        n_pop += pop_event;
        n_feed += feed_event;
        n_coll += collision_event;
        n_rec += rec_valid;
        n_drop += rec_dropped;
        if (tag_valid) last_tag = tag_id;
        if (rec_valid || rec_dropped) last_kind = rec_out.kind;
        if (cycles == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'b1;
        rd(SSEL_OFS_CTRL, 32'h0000_0000);
        rd(SSEL_OFS_COUNTER, 32'h0000_0000);
        rd(SSEL_OFS_STATUS, 32'h0000_0000);
        rd(SSEL_OFS_COLL_CNT, 32'h0000_0000);
        rd(SSEL_OFS_FILTER, 32'h0000_00ff);
        rd(4'hf, 32'h0000_0000);
        wr(SSEL_OFS_COUNTER, 32'h0000_0003);
        ops(4, 1'b1, 1'b0);
        rd(SSEL_OFS_COUNTER, 32'h0000_0003);
        wr(SSEL_OFS_RELOAD, 32'h0000_0004);
        wr(SSEL_OFS_CTRL, 32'h0000_0001);
        ops(2, 1'b0, 1'b0);
        rd(SSEL_OFS_COUNTER, 32'h0000_0003);
        ops(2, 1'b1, 1'b1);
        rd(SSEL_OFS_COUNTER, 32'h0000_0003);
        cmp("pops", 0, n_pop);
        ops(2, 1'b1, 1'b0);
        rd(SSEL_OFS_COUNTER, 32'h0000_0001);
        cmp("pops", 2, n_pop);
        ops(1, 1'b1, 1'b0);
        cmp("feeds", 1, n_feed);
        cmp("tag", n_ops - 1, last_tag);
        rd(SSEL_OFS_COUNTER, 32'h0000_0004);
        wr(SSEL_OFS_RELOAD, 32'h0000_0001);
        wr(SSEL_OFS_COUNTER, 32'h0000_0001);
        ops(2, 1'b1, 1'b0);
        cmp("colls", 1, n_coll);
        cmp("feeds", 2, n_feed);
        rd(SSEL_OFS_STATUS, 32'h0000_0029);
        rd(SSEL_OFS_COLL_CNT, 32'h0000_0001);
        cmp("recs", 0, n_rec);
        wr(SSEL_OFS_STATUS, 32'h0000_0001);
        rd(SSEL_OFS_STATUS, 32'h0000_0028);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) ops(2, 1'b1, 1'b0);
            ret(2'(k));
            cmp("recs", k + 1, n_rec);
            cmp("kind", k, last_kind);
        end
        wr(SSEL_OFS_FILTER, 32'h0000_00fe);
        ops(1, 1'b1, 1'b0);
        ret(2'h0);
        cmp("drops", 1, n_drop);
        cmp("recs", 4, n_rec);
        cmp("rec id", n_ops - 1, rec_out.id);
        cmp("rec pc", 32'h0000_1000, rec_out.pc);
        cmp("rec addr", 32'h0000_2000, rec_out.addr);
        cmp("rec latency", 5, rec_out.latency);
        wr(SSEL_OFS_CTRL, 32'h0000_ff03);
        wr(SSEL_OFS_COUNTER, 32'h0000_0001);
        repeat (300) if (n_feed == 5) ops(1, 1'b1, 1'b0);
        cmp("feeds", 6, n_feed);
        rd(SSEL_OFS_STATUS, 32'h0000_0024);
        rd(SSEL_OFS_COUNTER, 32'h0000_0001);
        report_and_stop();
    end
endmodule : tb

`default_nettype wire
